/* File: shared/ccr_pkg.sv */
package ccr_pkg;

   // register byte offsets on the control bus
   localparam logic [7:0] CCR_OFF_PC   = 8'h00;
   localparam logic [7:0] CCR_OFF_PSW  = 8'h04;
   localparam logic [7:0] CCR_OFF_SP   = 8'h08;
   localparam logic [7:0] CCR_OFF_CMD  = 8'h0c;
   localparam logic [7:0] CCR_OFF_ADDR = 8'h10;
   localparam logic [7:0] CCR_OFF_DATA = 8'h14;
   localparam logic [7:0] CCR_OFF_JREG = 8'h18;
   localparam logic [7:0] CCR_OFF_INFO = 8'h1c;

   // address map
   localparam logic [15:0] CCR_VEC_BASE   = 16'h0000;
   localparam logic [15:0] CCR_VEC_END    = 16'h0013;
   localparam logic [15:0] CCR_TABLE_CALL_INSTRUCTION_BASE = 16'h0040;
   localparam logic [15:0] CCR_TABLE_CALL_INSTRUCTION_END  = 16'h007f;
   localparam logic [15:0] CCR_DISP_BASE  = 16'hfa00;
   localparam logic [15:0] CCR_DISP_END   = 16'hfa16;
   localparam logic [15:0] CCR_RAM_BASE_L = 16'hfd00;
   localparam logic [15:0] CCR_RAM_BASE_S = 16'hfe00;
   localparam logic [15:0] CCR_RAM_END    = 16'hfeff;
   localparam logic [15:0] CCR_SFR_BASE   = 16'hff00;
   localparam int          CCR_RAM_BYTES  = 512;
   localparam int          CCR_DISP_BYTES = 23;

   // vector slots: reset, watchdog, ext pin, adc, watch timer, timer a, timer b, key, interval
   localparam logic [8:0][15:0] CCR_VEC_TAB = {
      16'h0012, 16'h0010, 16'h000e, 16'h000c, 16'h000a,
      16'h0008, 16'h0006, 16'h0004, 16'h0000};

   // status word layout and reset value
   localparam logic [7:0] CCR_PSW_RESET = 8'h02;
   localparam int         CCR_PSW_IE    = 7;
   localparam int         CCR_PSW_Z     = 6;
   localparam int         CCR_PSW_AC    = 4;
   localparam int         CCR_PSW_CY    = 0;
   localparam logic [15:0] CCR_SP_RESET = 16'h0000;

   // region codes
   localparam logic [2:0] CCR_RG_NONE  = 3'h0;
   localparam logic [2:0] CCR_RG_VECT  = 3'h1;
   localparam logic [2:0] CCR_RG_TABLE_CALL_INSTRUCTION = 3'h2;
   localparam logic [2:0] CCR_RG_ROM   = 3'h3;
   localparam logic [2:0] CCR_RG_DISP  = 3'h4;
   localparam logic [2:0] CCR_RG_RAM   = 3'h5;
   localparam logic [2:0] CCR_RG_SFR   = 3'h6;

   // command opcodes
   localparam logic [3:0] CCR_OP_NOP   = 4'h0;
   localparam logic [3:0] CCR_OP_STEP  = 4'h1;
   localparam logic [3:0] CCR_OP_BRIMM = 4'h2;
   localparam logic [3:0] CCR_OP_BRREG = 4'h3;
   localparam logic [3:0] CCR_OP_INT   = 4'h4;
   localparam logic [3:0] CCR_OP_TABLE_CALL_INSTRUCTION = 4'h5;
   localparam logic [3:0] CCR_OP_PUSHP = 4'h6;
   localparam logic [3:0] CCR_OP_POPP  = 4'h7;
   localparam logic [3:0] CCR_OP_RETURN_FROM_INTERRUPT  = 4'h8;
   localparam logic [3:0] CCR_OP_DI    = 4'h9;
   localparam logic [3:0] CCR_OP_EI    = 4'ha;
   localparam logic [3:0] CCR_OP_ALU   = 4'hb;
   localparam logic [3:0] CCR_OP_ROT   = 4'hc;
   localparam logic [3:0] CCR_OP_BITCY = 4'hd;

   localparam logic [1:0] CCR_RESP_OKAY   = 2'b00;
   localparam logic [1:0] CCR_RESP_SLVERR = 2'b10;

   typedef struct packed {
      logic [15:0] imm;
      logic [3:0]  arg;
      logic [3:0]  op;
   } ccr_cmd_t;

   typedef struct packed {
      logic [15:0] pc;
      logic [7:0]  status_word;
      logic [15:0] sp;
      logic        busy;
   } ccr_core_t;

   typedef enum logic [2:0] {ST_IDLE, ST_PUSH, ST_POP, ST_VLO, ST_VHI} ccr_state_t;

endpackage

/* File: verilog/ccr_cpu_ctrl.sv */
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
module ccr_cpu_ctrl #(
   parameter int ROM_BYTES = 4096,
   parameter bit LARGE_RAM = 1'b0
) (
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // axi4-lite write address and data
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic [2:0]        s_axi_awprot,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // axi4-lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic [2:0]        s_axi_arprot,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // core state
   output ccr_pkg::ccr_core_t     core
);
   import ccr_pkg::*;

   localparam int          RA        = (ROM_BYTES > 1) ? $clog2(ROM_BYTES) : 1;
   localparam logic [16:0] ROM_LIMIT = 17'(ROM_BYTES);

   logic [15:0] pc_reg;
   logic [7:0]  psw_reg;
   logic [15:0] sp_reg;
   logic [15:0] addr_reg;
   logic [15:0] jreg_reg;
   logic        int_taken_reg;
   ccr_state_t  state_reg;
   logic [1:0]  cnt_reg;
   logic [23:0] pushq_reg;
   logic        vec_pend_reg;
   logic [15:0] vaddr_reg;
   logic [7:0]  vec_lo_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic        rvalid_reg;
   logic [1:0]  rresp_reg;
   logic [31:0] rdata_reg;

   logic [7:0]  rom_mem  [ROM_BYTES];
   logic [7:0]  ram_mem  [CCR_RAM_BYTES];
   logic [7:0]  disp_mem [CCR_DISP_BYTES];

   ////////////////////////////////////////////////////////////////////////////
   // address decode and byte access

   function automatic logic [2:0] region_of(input logic [15:0] a);
      logic [15:0] rb;
      rb = LARGE_RAM ? CCR_RAM_BASE_L : CCR_RAM_BASE_S;
      if (a >= CCR_SFR_BASE) return CCR_RG_SFR;
      if (a >= rb && a <= CCR_RAM_END) return CCR_RG_RAM;
      if (a >= CCR_DISP_BASE && a <= CCR_DISP_END) return CCR_RG_DISP;
      if ({1'b0, a} >= ROM_LIMIT) return CCR_RG_NONE;
      if (a <= CCR_VEC_END) return CCR_RG_VECT;
      if (a >= CCR_TABLE_CALL_INSTRUCTION_BASE && a <= CCR_TABLE_CALL_INSTRUCTION_END) return CCR_RG_TABLE_CALL_INSTRUCTION;
      return CCR_RG_ROM;
   endfunction

   // ram is indexed from FD00H so that both variants share one array
   function automatic logic [7:0] mem_rd(input logic [15:0] a);
      case (region_of(a))
         CCR_RG_VECT, CCR_RG_TABLE_CALL_INSTRUCTION, CCR_RG_ROM: return rom_mem[a[RA-1:0]];
         CCR_RG_RAM:  return ram_mem[a[8:0] ^ 9'h100];
         CCR_RG_DISP: return disp_mem[a[4:0]];
         default:     return 8'h00;
      endcase
   endfunction

   function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // bus decode

   logic      idle;
   logic      wr_fire;
   logic      rd_fire;
   logic      w_map;
   ccr_cmd_t  cmd;
   logic      cmd_go;
   logic      wr_pc;
   logic      wr_psw;
   logic      wr_sp;
   logic      wr_data;
   logic [31:0] w_pc;
   logic [31:0] w_psw;
   logic [31:0] w_sp;
   logic [31:0] w_cmd;
   logic [31:0] w_addr;
   logic [31:0] w_jreg;

   assign idle    = (state_reg == ST_IDLE);
   assign wr_fire = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
   assign rd_fire = s_axi_arvalid & ~rvalid_reg;
   assign w_map   = (s_axi_awaddr[7:5] == 3'h0) && (s_axi_awaddr[1:0] == 2'h0);
   assign w_cmd   = wmerge(32'h0, s_axi_wdata, s_axi_wstrb);
   assign cmd     = ccr_cmd_t'(w_cmd[23:0]);
   // writes that move core state are dropped while a sequence is running
   assign cmd_go  = wr_fire && idle && (s_axi_awaddr == CCR_OFF_CMD);
   assign wr_pc   = wr_fire && idle && (s_axi_awaddr == CCR_OFF_PC);
   assign wr_psw  = wr_fire && idle && (s_axi_awaddr == CCR_OFF_PSW);
   assign wr_sp   = wr_fire && idle && (s_axi_awaddr == CCR_OFF_SP);
   assign wr_data = wr_fire && idle && (s_axi_awaddr == CCR_OFF_DATA);
   assign w_pc    = wmerge({16'h0, pc_reg}, s_axi_wdata, s_axi_wstrb);
   assign w_psw   = wmerge({24'h0, psw_reg}, s_axi_wdata, s_axi_wstrb);
   assign w_sp    = wmerge({16'h0, sp_reg}, s_axi_wdata, s_axi_wstrb);
   assign w_addr  = wmerge({16'h0, addr_reg}, s_axi_wdata, s_axi_wstrb);
   assign w_jreg  = wmerge({16'h0, jreg_reg}, s_axi_wdata, s_axi_wstrb);

   assign s_axi_awready = wr_fire;
   assign s_axi_wready  = wr_fire;
   assign s_axi_arready = rd_fire;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rresp   = rresp_reg;
   assign s_axi_rdata   = rdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // command decode: interrupt gate, alu flags

   logic        int_src_ok;
   logic        int_accept;
   logic [7:0]  opa;
   logic [7:0]  opb;
   logic [8:0]  sum;
   logic [4:0]  nib;
   logic        ac_new;
   logic [15:0] vec_word;
   logic [15:0] table_call_instruction_addr;

   assign int_src_ok = (cmd.arg != 4'h0) && (cmd.arg <= 4'h8);
   // imm[1] marks a non-maskable source, imm[0] is the source's own mask flag
   assign int_accept = cmd_go && (cmd.op == CCR_OP_INT) && int_src_ok &&
                       (cmd.imm[1] || (psw_reg[CCR_PSW_IE] && !cmd.imm[0]));
   assign opa = cmd.imm[15:8];
   assign opb = cmd.imm[7:0];
   assign sum = cmd.arg[0] ? ({1'b0, opa} - {1'b0, opb}) : ({1'b0, opa} + {1'b0, opb});
   assign nib = {1'b0, opa[3:0]} + {1'b0, opb[3:0]};
   assign ac_new = cmd.arg[0] ? (opa[3:0] < opb[3:0]) : nib[4];
   assign vec_word   = {mem_rd(vaddr_reg + 16'h0001), vec_lo_reg};
   assign table_call_instruction_addr = CCR_TABLE_CALL_INSTRUCTION_BASE + {10'h0, cmd.imm[4:0], 1'b0};

   ////////////////////////////////////////////////////////////////////////////
   // sequencer: pushes, pops and vector fetches

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg    <= ST_VLO;
         vaddr_reg    <= CCR_VEC_BASE;
         cnt_reg      <= 2'h0;
         pushq_reg    <= 24'h0;
         vec_pend_reg <= 1'b0;
         vec_lo_reg   <= 8'h00;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               if (int_accept) begin
                  state_reg    <= ST_PUSH;
                  cnt_reg      <= 2'h3;
                  pushq_reg    <= {psw_reg, pc_reg[15:8], pc_reg[7:0]};
                  vec_pend_reg <= 1'b1;
                  vaddr_reg    <= CCR_VEC_TAB[cmd.arg];
               end else if (cmd_go && cmd.op == CCR_OP_TABLE_CALL_INSTRUCTION) begin
                  state_reg    <= ST_PUSH;
                  cnt_reg      <= 2'h2;
                  pushq_reg    <= {pc_reg[15:8], pc_reg[7:0], 8'h00};
                  vec_pend_reg <= 1'b1;
                  vaddr_reg    <= table_call_instruction_addr;
               end else if (cmd_go && cmd.op == CCR_OP_PUSHP) begin
                  state_reg    <= ST_PUSH;
                  cnt_reg      <= 2'h1;
                  pushq_reg    <= {psw_reg, 16'h0000};
                  vec_pend_reg <= 1'b0;
               end else if (cmd_go && cmd.op == CCR_OP_POPP) begin
                  state_reg <= ST_POP;
                  cnt_reg   <= 2'h1;
               end else if (cmd_go && cmd.op == CCR_OP_RETURN_FROM_INTERRUPT) begin
                  state_reg <= ST_POP;
                  cnt_reg   <= 2'h3;
               end
            end
            ST_PUSH: begin
               pushq_reg <= {pushq_reg[15:0], 8'h00};
               cnt_reg   <= cnt_reg - 2'h1;
               if (cnt_reg == 2'h1) state_reg <= vec_pend_reg ? ST_VLO : ST_IDLE;
            end
            ST_POP: begin
               cnt_reg <= cnt_reg - 2'h1;
               if (cnt_reg == 2'h1) state_reg <= ST_IDLE;
            end
            ST_VLO: begin
               vec_lo_reg <= mem_rd(vaddr_reg);
               state_reg  <= ST_VHI;
            end
            ST_VHI: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // program counter

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pc_reg <= 16'h0000;
      end else if (state_reg == ST_VHI) begin
         pc_reg <= vec_word;
      end else if (state_reg == ST_POP && cnt_reg == 2'h3) begin
         pc_reg[7:0] <= mem_rd(sp_reg);
      end else if (state_reg == ST_POP && cnt_reg == 2'h2) begin
         pc_reg[15:8] <= mem_rd(sp_reg);
      end else if (wr_pc) begin
         pc_reg <= w_pc[15:0];
      end else if (cmd_go && cmd.op == CCR_OP_STEP) begin
         pc_reg <= pc_reg + {12'h000, cmd.arg};
      end else if (cmd_go && cmd.op == CCR_OP_BRIMM) begin
         pc_reg <= cmd.imm;
      end else if (cmd_go && cmd.op == CCR_OP_BRREG) begin
         pc_reg <= jreg_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status word

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         psw_reg <= CCR_PSW_RESET;
      end else if (state_reg == ST_POP && cnt_reg == 2'h1) begin
         psw_reg <= mem_rd(sp_reg);
      end else if (wr_psw) begin
         psw_reg <= w_psw[7:0];
      end else if (int_accept || (cmd_go && cmd.op == CCR_OP_DI)) begin
         psw_reg[CCR_PSW_IE] <= 1'b0;
      end else if (cmd_go && cmd.op == CCR_OP_EI) begin
         psw_reg[CCR_PSW_IE] <= 1'b1;
      end else if (cmd_go && cmd.op == CCR_OP_ALU) begin
         psw_reg[CCR_PSW_Z]  <= (sum[7:0] == 8'h00);
         psw_reg[CCR_PSW_AC] <= ac_new;
         psw_reg[CCR_PSW_CY] <= sum[8];
      end else if (cmd_go && cmd.op == CCR_OP_ROT) begin
         // arg[0] picks a right rotate; the shifted-out bit lands in carry
         psw_reg[CCR_PSW_CY] <= cmd.arg[0] ? opb[0] : opb[7];
      end else if (cmd_go && cmd.op == CCR_OP_BITCY) begin
         unique case (cmd.arg[1:0])
            2'h0: psw_reg[CCR_PSW_CY] <= opb[0];
            2'h1: psw_reg[CCR_PSW_CY] <= psw_reg[CCR_PSW_CY] & opb[0];
            2'h2: psw_reg[CCR_PSW_CY] <= psw_reg[CCR_PSW_CY] | opb[0];
            2'h3: psw_reg[CCR_PSW_CY] <= psw_reg[CCR_PSW_CY] ^ opb[0];
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // stack pointer and software-held words

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sp_reg <= CCR_SP_RESET;
      end else if (state_reg == ST_PUSH) begin
         sp_reg <= sp_reg - 16'h0001;
      end else if (state_reg == ST_POP) begin
         sp_reg <= sp_reg + 16'h0001;
      end else if (wr_sp) begin
         sp_reg <= w_sp[15:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         addr_reg      <= 16'h0000;
         jreg_reg      <= 16'h0000;
         int_taken_reg <= 1'b0;
      end else begin
         if (wr_fire && s_axi_awaddr == CCR_OFF_ADDR)
            addr_reg <= w_addr[15:0];
         if (wr_fire && s_axi_awaddr == CCR_OFF_JREG)
            jreg_reg <= w_jreg[15:0];
         if (cmd_go && cmd.op == CCR_OP_INT) int_taken_reg <= int_accept;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // memory write port: the sequencer owns it while busy

   logic        mem_we;
   logic [15:0] mem_wa;
   logic [7:0]  mem_wd;

   assign mem_we = (state_reg == ST_PUSH) || (wr_data && s_axi_wstrb[0]);
   assign mem_wa = (state_reg == ST_PUSH) ? (sp_reg - 16'h0001) : addr_reg;
   assign mem_wd = (state_reg == ST_PUSH) ? pushq_reg[23:16] : s_axi_wdata[7:0];

   always_ff @(posedge aclk) begin
      if (mem_we) begin
         case (region_of(mem_wa))
            CCR_RG_VECT, CCR_RG_TABLE_CALL_INSTRUCTION, CCR_RG_ROM: rom_mem[mem_wa[RA-1:0]] <= mem_wd;
            CCR_RG_RAM:  ram_mem[mem_wa[8:0] ^ 9'h100] <= mem_wd;
            CCR_RG_DISP: disp_mem[mem_wa[4:0]] <= mem_wd;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus responses

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= CCR_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= w_map ? CCR_RESP_OKAY : CCR_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rresp_reg  <= CCR_RESP_OKAY;
         rdata_reg  <= 32'h0000_0000;
      end else if (rd_fire) begin
         rvalid_reg <= 1'b1;
         rresp_reg  <= CCR_RESP_OKAY;
         unique case (s_axi_araddr)
            CCR_OFF_PC:   rdata_reg <= {16'h0, pc_reg};
            CCR_OFF_PSW:  rdata_reg <= {24'h0, psw_reg};
            CCR_OFF_SP:   rdata_reg <= {16'h0, sp_reg};
            CCR_OFF_CMD:  rdata_reg <= 32'h0000_0000;
            CCR_OFF_ADDR: rdata_reg <= {13'h0, region_of(addr_reg), addr_reg};
            CCR_OFF_DATA: rdata_reg <= {24'h0, mem_rd(addr_reg)};
            CCR_OFF_JREG: rdata_reg <= {16'h0, jreg_reg};
            CCR_OFF_INFO: rdata_reg <= {13'h0, ~idle, int_taken_reg, LARGE_RAM,
                                        ROM_LIMIT[15:0]};
            default: begin
               rdata_reg <= 32'h0000_0000;
               rresp_reg <= CCR_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   assign core.pc   = pc_reg;
   assign core.status_word  = psw_reg;
   assign core.sp   = sp_reg;
   assign core.busy = ~idle;

   ////////////////////////////////////////////////////////////////////////////
   // checks

   property p_vec_load;
      @(posedge aclk) disable iff (!aresetn)
      // memories are not reset, so the fetch right after release may read unwritten rom
      state_reg == ST_VLO && $past(aresetn)
         |=> state_reg == ST_VHI ##1 pc_reg == $past(vec_word);
   endproperty
   a_vec_load: assert property (p_vec_load) else $error("vector not loaded");

   property p_psw_reset;
      @(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> psw_reg == 8'h02 && pc_reg == 16'h0000;
   endproperty
   a_psw_reset: assert property (p_psw_reset) else $error("bad reset psw");

   property p_step;
      @(posedge aclk) disable iff (!aresetn)
      cmd_go && cmd.op == CCR_OP_STEP |=> pc_reg == $past(pc_reg) + {12'h000, $past(cmd.arg)};
   endproperty
   a_step: assert property (p_step) else $error("pc step wrong");

   property p_int_block;
      @(posedge aclk) disable iff (!aresetn)
      cmd_go && cmd.op == CCR_OP_INT && !cmd.imm[1] && !psw_reg[CCR_PSW_IE]
         |=> state_reg == ST_IDLE && $stable(pc_reg);
   endproperty
   a_int_block: assert property (p_int_block) else $error("masked int taken");

   property p_int_seq;
      @(posedge aclk) disable iff (!aresetn)
      int_accept
         |=> (!psw_reg[CCR_PSW_IE] && state_reg == ST_PUSH) [*3] ##1 state_reg == ST_VLO;
   endproperty
   a_int_seq: assert property (p_int_seq) else $error("int entry wrong");

   property p_push_sp;
      @(posedge aclk) disable iff (!aresetn)
      state_reg == ST_PUSH |=> sp_reg == $past(sp_reg) - 16'h0001;
   endproperty
   a_push_sp: assert property (p_push_sp) else $error("push sp wrong");

   property p_pop_psw;
      @(posedge aclk) disable iff (!aresetn)
      state_reg == ST_POP && cnt_reg == 2'h1
         |=> psw_reg == $past(mem_rd(sp_reg)) && sp_reg == $past(sp_reg) + 16'h0001;
   endproperty
   a_pop_psw: assert property (p_pop_psw) else $error("psw pop wrong");

   property p_zero;
      @(posedge aclk) disable iff (!aresetn)
      cmd_go && cmd.op == CCR_OP_ALU |=> psw_reg[CCR_PSW_Z] == ($past(sum[7:0]) == 8'h00);
   endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");

   property p_bus_resp;
      @(posedge aclk) disable iff (!aresetn)
      wr_fire |=> s_axi_bvalid && (s_axi_bresp == CCR_RESP_OKAY) == $past(w_map);
   endproperty
   a_bus_resp: assert property (p_bus_resp) else $error("write answer wrong");

endmodule // ccr_cpu_ctrl

/* File: tb/tb_cpu_control_regs_memory_map.sv */
module tb_cpu_control_regs_memory_map;
   timeunit 1ns;
   timeprecision 1ps;
   import ccr_pkg::*;

   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, rs;
   logic [31:0] rdata, rdv;
   ccr_core_t   core;
   int          n_mismatch = 0;
   int          checks = 0;

   // alu/rotate commands and the status word each one leaves
   localparam logic [31:0] CM [4] = '{32'h00ff010b, 32'h0010101b, 32'h0000011b, 32'h0000801c};
   localparam logic [7:0]  PX [4] = '{8'h53, 8'h42, 8'h13, 8'h12};
   // probe addresses and their region codes (small ram variant)
   localparam logic [15:0] AM [4] = '{16'hfa16, 16'hff00, 16'hfd00, 16'hfe00};
   localparam logic [2:0]  RG [4] = '{3'h4, 3'h6, 3'h0, 3'h5};

   always #4 aclk = ~aclk;

   ccr_cpu_ctrl DUT (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .core(core));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // command, pc, status, sp and data writes are dropped while the sequencer runs, so wait for idle first
   task automatic idle;
      do @(posedge aclk); while (core.busy !== 1'b0);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      idle;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do @(posedge aclk); while (awready !== 1'b1);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      bready <= 1'b1;
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      rdv = rdata;
      rs = rresp;
   endtask

   task automatic complete_run;
      if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_vec_int;
      // watchdog vector 1234 split low byte even, high byte odd
      wr(8'h10, 32'h4); wr(8'h14, 32'h34); wr(8'h10, 32'h5); wr(8'h14, 32'h12);
      wr(8'h08, 32'hff00);
      wr(8'h0c, 32'h00010002); chk(core.pc, 16'h0100);
      wr(8'h0c, 32'h31); chk(core.pc, 16'h0103);
      wr(8'h0c, 32'ha); rd(8'h04); chk(rdv, 32'h82);
      wr(8'h0c, 32'h14); idle;
      chk({core.pc, core.status_word, core.sp}, {16'h1234, 8'h02, 16'hfefd});
      wr(8'h0c, 32'h8); idle;
      chk({core.pc, core.status_word, core.sp}, {16'h0103, 8'h82, 16'hff00});
      wr(8'h0c, 32'h9); wr(8'h0c, 32'h14); idle; chk(core.pc, 16'h0103);
      wr(8'h0c, 32'h214); idle; chk(core.pc, 16'h1234);
   endtask

   task automatic t_flags;
      for (int i = 0; i < 4; i++) begin
         wr(8'h0c, CM[i]); chk(core.status_word, PX[i]);
      end
      // push status, change it, pop it back
      wr(8'h0c, 32'h6); wr(8'h0c, 32'ha); wr(8'h0c, 32'h7); idle;
      chk({core.status_word, core.sp}, {8'h12, 16'hfefd});
      wr(8'h0c, 32'h10d); chk(core.status_word, 8'h13);
      wr(8'h0c, 32'h13d); chk(core.status_word, 8'h12);
   endtask

   task automatic t_map;
      for (int i = 0; i < 4; i++) begin
         wr(8'h10, {16'h0, AM[i]}); rd(8'h10); chk(rdv, {13'h0, RG[i], AM[i]});
      end
      rd(8'h20); chk(rs, 2'b10);
      wr(8'h18, 32'h4321); wr(8'h0c, 32'h3); chk(core.pc, 16'h4321);
      rd(8'h1c); chk(rdv, 32'h0002_1000);
      // table entry 1 at 0042H/0043H holds abcd
      wr(8'h10, 32'h42); wr(8'h14, 32'hcd); wr(8'h10, 32'h43); wr(8'h14, 32'hab);
      wr(8'h0c, 32'h105); idle;
      chk({core.pc, core.sp}, {16'habcd, 16'hfefb});
   endtask

   task automatic t_reset;
      // reset vector 5678 loaded, then reset taken while the sequencer is idle
      wr(8'h10, 32'h0); wr(8'h14, 32'h78); wr(8'h10, 32'h1); wr(8'h14, 32'h56);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      chk(core.status_word, 8'h02);
      idle;
      chk({core.pc, core.status_word}, {16'h5678, 8'h02});
   endtask

   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      chk(core.status_word, 8'h02);
      t_vec_int;
      t_flags;
      t_map;
      t_reset;
      complete_run;
   end

   initial begin
      #50us;
      n_mismatch++;
      complete_run;
   end

endmodule // tb_cpu_control_regs_memory_map
